// ==== dsp_half_block.sv ====
// DSP half block: configurable multipliers, two-product adders, complex
// Behaviour
// - Up to 4x9, 3x12 or 2x18 products.
// - Operand width picks 9, 12 or 18 multiplier.
// - Narrow operands are zero-padded at LSBs.
// - Sign controls are dynamic, optionally registered.
// - Operand and product stages bypass independently.
// - Optional pipeline stage after products adds latency.
// - Round and saturate only in 18-bit independent and adder modes.
// - 36x36 product built from four 18x18 multipliers.
// - 36-bit mode combines partials after pipeline stage.
// - Double mode gives unsigned full 72-bit wide product.
// - Two product adders per half block.
// - Adders statically add or subtract products.
// - Loopback returns upper 18 sum bits, drops lower.
// - Zero-loopback high zeroes the fed-back operand.
// - Loopback or general adder mode is static.
// - Adder result must fit 36 bits.
// - Adder result may round, saturate and pipeline.
// - One 18-bit complex multiply per half block.
// - Real is difference, imaginary is sum of products.
// - Complex mode treats every operand as signed.
// - Sign high means signed; either signed gives signed.
// - Stage groups: rising edge, own enable and clear.
// - Only lane 0 input loops back, 18x18 only.
`timescale 1ns/10ps
module dsp_half_block (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  dsp_link_if.dev link
);
  import dsp_mult_pkg::*;

  logic [3:0] grp_rst_n;
  logic [BUS_W-1:0] a_q;
  logic [BUS_W-1:0] next_a_q;
  logic [BUS_W-1:0] b_q;
  logic [BUS_W-1:0] next_b_q;
  logic [BUS_W-1:0] a_s;
  logic [BUS_W-1:0] b_s;
  logic sa_q;
  logic next_sa_q;
  logic sb_q;
  logic next_sb_q;
  logic sa_e;
  logic sb_e;
  logic [4:0] native;
  logic [5:0] shift;
  logic ind_mode;
  logic wide_mode;
  logic pair_mode;
  logic loop_mode;
  logic cplx_mode;
  logic [LANE_W-1:0] fb_q;
  logic [LANE_W-1:0] next_fb_q;
  logic [LANE_W-1:0] fb_sel;
  logic [LANES-1:0][PROD_W-1:0] p_c;
  logic [LANES-1:0][PROD_W-1:0] p_q;
  logic [LANES-1:0][PROD_W-1:0] next_p_q;
  logic [LANES-1:0][PROD_W-1:0] p_s;
  logic [LANES-1:0][PROD_W-1:0] pp_q;
  logic [LANES-1:0][PROD_W-1:0] next_pp_q;
  logic [LANES-1:0][PROD_W-1:0] pp_s;
  logic signed [PROD_W:0] sum0;
  logic signed [PROD_W:0] sum1;
  logic signed [WIDE_W-1:0] wide;
  logic rnd_ok;
  logic [BUS_W-1:0] res_c;
  logic [BUS_W-1:0] res_q;
  logic [BUS_W-1:0] next_res_q;

  // Padded operand times padded operand, scaled back to native precision
  function automatic logic [PROD_W-1:0] lane_mult(
    input logic [LANE_W-1:0] x,
    input logic [LANE_W-1:0] y,
    input logic sx,
    input logic sy,
    input logic [5:0] sh
  );
    logic signed [PROD_W-1:0] full;
    full = $signed({sx & x[LANE_W-1], x}) * $signed({sy & y[LANE_W-1], y});
    return full >>> sh;
  endfunction

  // Round to the upper half, then clamp to a signed 36-bit range
  function automatic logic [RES_W-1:0] rnd_sat(
    input logic signed [PROD_W:0] v,
    input logic rnd,
    input logic sat
  );
    logic signed [PROD_W:0] t;
    t = v;
    if (rnd) begin
      t = t + RND_HALF;
      t[RND_POS-1:0] = '0;
    end
    if (sat && t > SAT_MAX) begin
      t = SAT_MAX;
    end else if (sat && t < SAT_MIN) begin
      t = SAT_MIN;
    end
    return t[RES_W-1:0];
  endfunction

  // Clear only comes from a fabric flop, so the gated reset cannot glitch
  assign grp_rst_n = {4{rst_n_i}} & ~link.aclr;

  // Mode decode; kind, width and subtract are held static by the fabric
  always_comb begin
    native = native_width(link.op_width);
    shift = {5'(LANE_W) - native, 1'b0};
    ind_mode = 1'b0;
    wide_mode = 1'b0;
    pair_mode = 1'b0;
    loop_mode = 1'b0;
    cplx_mode = 1'b0;
    case (link.kind)
      KIND_M36: wide_mode = 1'b1;
      KIND_DOUBLE: wide_mode = 1'b1;
      KIND_ADD2: pair_mode = 1'b1;
      KIND_LOOP: loop_mode = 1'b1;
      KIND_CPLX: cplx_mode = 1'b1;
      default: ind_mode = 1'b1;
    endcase
  end

  // Input group: operands and sign controls
  always_comb begin
    next_a_q = link.ena[GRP_IN] ? link.a : a_q;
    next_b_q = link.ena[GRP_IN] ? link.b : b_q;
    next_sa_q = link.ena[GRP_IN] ? link.sign_a : sa_q;
    next_sb_q = link.ena[GRP_IN] ? link.sign_b : sb_q;
  end

  always_ff @(posedge mclk_i or negedge grp_rst_n[GRP_IN]) begin
    if (!grp_rst_n[GRP_IN]) begin
      a_q <= '0;
      b_q <= '0;
      sa_q <= 1'b0;
      sb_q <= 1'b0;
    end else begin
      a_q <= next_a_q;
      b_q <= next_b_q;
      sa_q <= next_sa_q;
      sb_q <= next_sb_q;
    end
  end

  assign a_s = link.stages[STG_IN] ? a_q : link.a;
  assign b_s = link.stages[STG_IN] ? b_q : link.b;

  always_comb begin
    sa_e = link.stages[STG_SIGN] ? sa_q : link.sign_a;
    sb_e = link.stages[STG_SIGN] ? sb_q : link.sign_b;
    if (cplx_mode) begin
      sa_e = 1'b1;
      sb_e = 1'b1;
    end else if (link.kind == KIND_DOUBLE) begin
      sa_e = 1'b0;
      sb_e = 1'b0;
    end
  end

  assign fb_sel = link.zero_loopback ? '0 : fb_q;

  // Lane routing: wide modes cross lo/hi halves, complex crosses re/im
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    logic [LANE_W-1:0] la;
    logic [LANE_W-1:0] lb;
    logic lsa;
    logic lsb;
    always_comb begin
      la = a_s[LANE_W*k +: LANE_W];
      lb = b_s[LANE_W*k +: LANE_W];
      lsa = sa_e;
      lsb = sb_e;
      if (wide_mode) begin
        la = a_s[LANE_W*(k%2) +: LANE_W];
        lb = b_s[LANE_W*(k/2) +: LANE_W];
        lsa = sa_e & (k%2 == 1);
        lsb = sb_e & (k/2 == 1);
      end else if (cplx_mode) begin
        la = a_s[LANE_W*(k%2) +: LANE_W];
        lb = b_s[LANE_W*((k%2)^(k/2)) +: LANE_W];
      end else if (loop_mode && k == 0) begin
        la = fb_sel;
      end
    end
    assign p_c[k] = lane_mult(la, lb, lsa, lsb, ind_mode ? shift : 6'h00);
  end

  // Product group and pipeline group
  always_comb begin
    next_p_q = link.ena[GRP_PROD] ? p_c : p_q;
    next_pp_q = link.ena[GRP_PIPE] ? p_s : pp_q;
  end

  always_ff @(posedge mclk_i or negedge grp_rst_n[GRP_PROD]) begin
    if (!grp_rst_n[GRP_PROD]) begin
      p_q <= '0;
    end else begin
      p_q <= next_p_q;
    end
  end

  always_ff @(posedge mclk_i or negedge grp_rst_n[GRP_PIPE]) begin
    if (!grp_rst_n[GRP_PIPE]) begin
      pp_q <= '0;
    end else begin
      pp_q <= next_pp_q;
    end
  end

  assign p_s = link.stages[STG_PROD] ? p_q : p_c;
  assign pp_s = link.stages[STG_PIPE] ? pp_q : p_s;

  // Combining logic after the pipeline stage
  always_comb begin
    sum0 = 39'($signed(pp_s[0])) + 39'($signed(pp_s[1]));
    sum1 = 39'($signed(pp_s[2])) + 39'($signed(pp_s[3]));
    if (cplx_mode || link.subtract) begin
      sum0 = 39'($signed(pp_s[0])) - 39'($signed(pp_s[1]));
    end
    if (!cplx_mode && link.subtract) begin
      sum1 = 39'($signed(pp_s[2])) - 39'($signed(pp_s[3]));
    end
    wide = WIDE_W'($signed(pp_s[0]))
         + (WIDE_W'($signed(pp_s[1])) <<< 18)
         + (WIDE_W'($signed(pp_s[2])) <<< 18)
         + (WIDE_W'($signed(pp_s[3])) <<< 36);
    rnd_ok = sa_e | sb_e;
    res_c = '0;
    if (wide_mode) begin
      res_c = wide[BUS_W-1:0];
    end else if (cplx_mode) begin
      res_c = {sum1[RES_W-1:0], sum0[RES_W-1:0]};
    end else if (pair_mode || loop_mode) begin
      res_c = {rnd_sat(sum1, link.round, link.saturate & rnd_ok),
               rnd_sat(sum0, link.round, link.saturate & rnd_ok)};
    end else if (native == 5'(NATIVE_9)) begin
      for (int k = 0; k < 4; k++) begin
        res_c[18*k +: 18] = pp_s[k][17:0];
      end
    end else if (native == 5'(NATIVE_12)) begin
      for (int k = 0; k < 3; k++) begin
        res_c[24*k +: 24] = pp_s[k][23:0];
      end
    end else begin
      res_c = {rnd_sat(39'($signed(pp_s[1])), link.round,
                       link.saturate & rnd_ok),
               rnd_sat(39'($signed(pp_s[0])), link.round,
                       link.saturate & rnd_ok)};
    end
  end

  // Loopback keeps only the upper half of the first sum
  always_comb begin
    next_fb_q = link.ena[GRP_OUT] ? sum0[RES_W-1:LANE_W] : fb_q;
    next_res_q = link.ena[GRP_OUT] ? res_c : res_q;
  end

  always_ff @(posedge mclk_i or negedge grp_rst_n[GRP_OUT]) begin
    if (!grp_rst_n[GRP_OUT]) begin
      fb_q <= '0;
      res_q <= '0;
    end else begin
      fb_q <= next_fb_q;
      res_q <= next_res_q;
    end
  end

  // Bypassing the output stage exposes the combining path directly
  assign link.result = link.stages[STG_OUT] ? res_q : res_c;
endmodule

// ==== dsp_mult_pkg.sv ====
// Shared constants, types and helpers for the DSP half-block multiplier
package dsp_mult_pkg;

  typedef enum logic [2:0] {
    KIND_IND,
    KIND_M36,
    KIND_DOUBLE,
    KIND_ADD2,
    KIND_LOOP,
    KIND_CPLX
  } kind_type;

  localparam int LANE_W = 18;
  localparam int LANES = 4;
  localparam int BUS_W = 72;
  localparam int PROD_W = 38;
  localparam int WIDE_W = 74;
  localparam int RES_W = 36;
  localparam int NATIVE_9 = 9;
  localparam int NATIVE_12 = 12;
  localparam int NATIVE_18 = 18;

  // Optional stage bypass bits
  localparam int STG_IN = 0;
  localparam int STG_SIGN = 1;
  localparam int STG_PROD = 2;
  localparam int STG_PIPE = 3;
  localparam int STG_OUT = 4;

  // Register groups, one enable and one clear each
  localparam int GRP_IN = 0;
  localparam int GRP_PROD = 1;
  localparam int GRP_PIPE = 2;
  localparam int GRP_OUT = 3;

  localparam int RND_POS = 18;
  localparam logic signed [38:0] RND_HALF = 39'h00_0002_0000;
  localparam logic signed [38:0] SAT_MAX = 39'h07_ffff_ffff;
  localparam logic signed [38:0] SAT_MIN = 39'h78_0000_0000;

  // Software register map of the fabric end
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_DYN = 8'h04;
  localparam logic [7:0] OFS_CLR = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  localparam logic [7:0] OFS_OPA = 8'h10;
  localparam logic [7:0] OFS_OPB = 8'h20;
  localparam logic [7:0] OFS_RES = 8'h30;
  localparam int CFG_KIND_POS = 0;
  localparam int CFG_OPW_POS = 4;
  localparam int CFG_SUB_POS = 9;
  localparam int CFG_STG_POS = 10;
  localparam int DYN_SA_POS = 0;
  localparam int DYN_SB_POS = 1;
  localparam int DYN_ZL_POS = 2;
  localparam int DYN_RND_POS = 3;
  localparam int DYN_SAT_POS = 4;
  localparam int DYN_ENA_POS = 8;
  localparam logic [4:0] OPW_RST = 5'h12;
  localparam logic [3:0] ENA_RST = 4'hf;

  // Native multiplier size chosen from the operand width
  function automatic logic [4:0] native_width(input logic [4:0] w);
    if (w <= 5'(NATIVE_9)) begin
      return 5'(NATIVE_9);
    end else if (w <= 5'(NATIVE_12)) begin
      return 5'(NATIVE_12);
    end
    return 5'(NATIVE_18);
  endfunction

endpackage

// ==== dsp_link_if.sv ====
// Connection between the fabric user logic and the DSP half block
`timescale 1ns/10ps
interface dsp_link_if;
  dsp_mult_pkg::kind_type kind;
  logic [4:0] op_width;
  logic subtract;
  logic [4:0] stages;
  logic [71:0] a;
  logic [71:0] b;
  logic sign_a;
  logic sign_b;
  logic zero_loopback;
  logic round;
  logic saturate;
  logic [3:0] ena;
  logic [3:0] aclr;
  logic [71:0] result;

  modport dev (
    input kind, op_width, subtract, stages, a, b, sign_a, sign_b,
    input zero_loopback, round, saturate, ena, aclr,
    output result
  );

  modport fab (
    output kind, op_width, subtract, stages, a, b, sign_a, sign_b,
    output zero_loopback, round, saturate, ena, aclr,
    input result
  );
endinterface

// ==== dsp_fabric_ctrl.sv ====
// Fabric end: APB register slave that drives the DSP half block
`timescale 1ns/10ps
module dsp_fabric_ctrl (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  dsp_link_if.fab link
);
  import dsp_mult_pkg::*;

  dsp_mult_pkg::kind_type kind_q;
  dsp_mult_pkg::kind_type next_kind_q;
  logic [4:0] opw_q;
  logic [4:0] next_opw_q;
  logic sub_q;
  logic next_sub_q;
  logic [4:0] stg_q;
  logic [4:0] next_stg_q;
  logic [7:0] dyn_q;
  logic [7:0] next_dyn_q;
  logic [3:0] ena_q;
  logic [3:0] next_ena_q;
  logic [3:0] aclr_q;
  logic [3:0] next_aclr_q;
  logic [LANES-1:0][LANE_W-1:0] opa_q;
  logic [LANES-1:0][LANE_W-1:0] next_opa_q;
  logic [LANES-1:0][LANE_W-1:0] opb_q;
  logic [LANES-1:0][LANE_W-1:0] next_opb_q;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic take;
  logic cfg_err;
  logic [4:0] w;

  function automatic logic in_block(input logic [7:0] addr,
                                    input logic [7:0] base);
    return addr[7:4] == base[7:4] && addr[1:0] == 2'h0;
  endfunction

  // Operand sits MSB-aligned in its lane, zeros below
  function automatic logic [LANE_W-1:0] pad(input logic [31:0] v,
                                            input logic [4:0] wd);
    return v[LANE_W-1:0] << (5'(LANE_W) - wd);
  endfunction

  // Unsigned full-width operands would need a 37-bit adder result
  assign cfg_err = (kind_q == KIND_ADD2 || kind_q == KIND_LOOP) &&
                   !dyn_q[DYN_SA_POS] && !dyn_q[DYN_SB_POS] &&
                   opw_q == 5'(LANE_W);

  always_comb begin
    take = psel_i && penable_i && pready_o;
    next_kind_q = kind_q;
    next_opw_q = opw_q;
    next_sub_q = sub_q;
    next_stg_q = stg_q;
    next_dyn_q = dyn_q;
    next_ena_q = ena_q;
    next_aclr_q = 4'h0;
    next_opa_q = opa_q;
    next_opb_q = opb_q;
    next_pready = psel_i && penable_i && !pready_o;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    w = pwdata_i[CFG_OPW_POS +: 5];
    if (w == 5'h00) begin
      w = 5'h01;
    end else if (w > 5'(LANE_W)) begin
      w = 5'(LANE_W);
    end
    if (paddr_i == OFS_CFG) begin
      next_prdata = 32'({stg_q, sub_q, opw_q, 1'b0, kind_q});
      if (take && pwrite_i) begin
        next_kind_q = kind_type'(pwdata_i[CFG_KIND_POS +: 3]);
        next_opw_q = w;
        next_sub_q = pwdata_i[CFG_SUB_POS];
        next_stg_q = pwdata_i[CFG_STG_POS +: 5];
      end
    end else if (paddr_i == OFS_DYN) begin
      next_prdata = 32'({ena_q, dyn_q});
      if (take && pwrite_i) begin
        next_dyn_q = pwdata_i[7:0];
        next_ena_q = pwdata_i[DYN_ENA_POS +: 4];
      end
    end else if (paddr_i == OFS_CLR) begin
      if (take && pwrite_i) begin
        next_aclr_q = pwdata_i[3:0];
      end
    end else if (paddr_i == OFS_STAT) begin
      next_prdata = 32'(cfg_err);
    end else if (in_block(paddr_i, OFS_OPA)) begin
      next_prdata = 32'(opa_q[paddr_i[3:2]]);
      if (take && pwrite_i) begin
        next_opa_q[paddr_i[3:2]] = pad(pwdata_i, opw_q);
      end
    end else if (in_block(paddr_i, OFS_OPB)) begin
      next_prdata = 32'(opb_q[paddr_i[3:2]]);
      if (take && pwrite_i) begin
        next_opb_q[paddr_i[3:2]] = pad(pwdata_i, opw_q);
      end
    end else if (in_block(paddr_i, OFS_RES) && paddr_i[3:2] != 2'h3) begin
      next_prdata = 32'(link.result >> (32 * paddr_i[3:2]));
    end else begin
      next_pslverr = 1'b1;
    end
    if (!next_pready) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_q <= KIND_IND;
      opw_q <= OPW_RST;
      sub_q <= 1'b0;
      stg_q <= 5'h00;
      dyn_q <= 8'h00;
      ena_q <= ENA_RST;
      aclr_q <= 4'h0;
      opa_q <= '0;
      opb_q <= '0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      kind_q <= next_kind_q;
      opw_q <= next_opw_q;
      sub_q <= next_sub_q;
      stg_q <= next_stg_q;
      dyn_q <= next_dyn_q;
      ena_q <= next_ena_q;
      aclr_q <= next_aclr_q;
      opa_q <= next_opa_q;
      opb_q <= next_opb_q;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
    end
  end

  assign link.kind = kind_q;
  assign link.op_width = opw_q;
  assign link.subtract = sub_q;
  assign link.stages = stg_q;
  assign link.a = opa_q;
  assign link.b = opb_q;
  assign link.sign_a = dyn_q[DYN_SA_POS];
  assign link.sign_b = dyn_q[DYN_SB_POS];
  assign link.zero_loopback = dyn_q[DYN_ZL_POS];
  assign link.round = dyn_q[DYN_RND_POS];
  assign link.saturate = dyn_q[DYN_SAT_POS];
  assign link.ena = ena_q;
  assign link.aclr = aclr_q;
endmodule

// ==== dsp_link_asserts.sv ====
// Checker on the link between the fabric end and the DSP half block
`timescale 1ns/10ps
module dsp_link_asserts
  import dsp_mult_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire dsp_mult_pkg::kind_type kind,
  input wire logic [4:0] op_width,
  input wire logic subtract,
  input wire logic [4:0] stages,
  input wire logic [71:0] a,
  input wire logic [71:0] b,
  input wire logic sign_a,
  input wire logic sign_b,
  input wire logic zero_loopback,
  input wire logic round,
  input wire logic saturate,
  input wire logic [3:0] ena,
  input wire logic [3:0] aclr,
  input wire logic [71:0] result
);
  logic bypass;
  logic plain;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Exact figures are simplest to know with every stage bypassed
  assign bypass = stages == 5'h00;
  assign plain = !round && !saturate;

  function automatic logic [35:0] mul18(input logic [17:0] x,
      input logic [17:0] y, input logic sx, input logic sy);
    logic signed [37:0] p;
    p = $signed({sx & x[17], x}) * $signed({sy & y[17], y});
    return p[35:0];
  endfunction

  function automatic logic [35:0] sum2(input logic [17:0] x0,
      input logic [17:0] y0, input logic [17:0] x1, input logic [17:0] y1,
      input logic sx, input logic sy, input logic sb);
    logic [35:0] p0;
    logic [35:0] p1;
    p0 = mul18(x0, y0, sx, sy);
    p1 = mul18(x1, y1, sx, sy);
    return sb ? p0 - p1 : p0 + p1;
  endfunction

  sequence s_steady;
    (stages == 5'h1f && ena == 4'hf && aclr == 4'h0 && kind == KIND_IND
      && op_width > 5'h0c && !sign_a && !sign_b && plain) [*5];
  endsequence

  sequence s_loop;
    kind == KIND_LOOP && bypass && plain && ena[3] && !aclr[3]
      && (sign_a || sign_b);
  endsequence

  property p_ind18;
    kind == KIND_IND && op_width > 5'h0c && bypass && plain |->
      result == {mul18(a[35:18], b[35:18], sign_a, sign_b),
                 mul18(a[17:0], b[17:0], sign_a, sign_b)};
  endproperty

  property p_ind9;
    kind == KIND_IND && op_width < 5'h0a && bypass && !sign_a && !sign_b
      |-> result[17:0] == a[17:9] * b[17:9]
        && result[71:54] == a[71:63] * b[71:63];
  endproperty

  property p_m36;
    (kind == KIND_DOUBLE || (kind == KIND_M36 && !sign_a && !sign_b))
      && bypass |-> result == a[35:0] * b[35:0];
  endproperty

  property p_add2;
    kind == KIND_ADD2 && bypass && plain && (sign_a || sign_b) |->
      result == {sum2(a[53:36], b[53:36], a[71:54], b[71:54], sign_a,
                      sign_b, subtract),
                 sum2(a[17:0], b[17:0], a[35:18], b[35:18], sign_a,
                      sign_b, subtract)};
  endproperty

  property p_cplx;
    kind == KIND_CPLX && bypass |->
      result == {sum2(a[17:0], b[35:18], a[35:18], b[17:0], 1'b1, 1'b1,
                      1'b0),
                 sum2(a[17:0], b[17:0], a[35:18], b[35:18], 1'b1, 1'b1,
                      1'b1)};
  endproperty

  property p_loop_zero;
    kind == KIND_LOOP && bypass && plain && zero_loopback
      && (sign_a || sign_b) |-> result[35:0] == sum2(18'h0, b[17:0],
        a[35:18], b[35:18], sign_a, sign_b, subtract);
  endproperty

  property p_loop_fb;
    s_loop ##1 (s_loop ##0 !zero_loopback) |-> result[35:0] ==
      sum2($past(result[35:18]), b[17:0], a[35:18], b[35:18], sign_a,
           sign_b, subtract);
  endproperty

  // Four used stages: the product appears four edges after its operands
  property p_latency;
    s_steady |-> result[35:0] ==
      mul18($past(a[17:0], 4), $past(b[17:0], 4), 1'b0, 1'b0);
  endproperty

  property p_aclr;
    aclr[3] && stages[4] |-> result == 72'h0;
  endproperty

  a_ind18: assert property (p_ind18)
    else $error("independent wide product wrong");
  a_ind9: assert property (p_ind9)
    else $error("independent narrow product wrong");
  a_m36: assert property (p_m36)
    else $error("wide product wrong");
  a_add2: assert property (p_add2)
    else $error("two product sum wrong");
  a_cplx: assert property (p_cplx)
    else $error("complex product wrong");
  a_loop_zero: assert property (p_loop_zero)
    else $error("zeroed loopback operand not zero");
  a_loop_fb: assert property (p_loop_fb)
    else $error("loopback operand not upper sum bits");
  a_latency: assert property (p_latency)
    else $error("pipelined product wrong or late");
  a_aclr: assert property (p_aclr)
    else $error("output group not cleared");
endmodule

// ==== dsp_multiplier_modes_test.sv ====
// Bench for the fabric end and DSP half block joined by their link
`timescale 1ns/10ps
module dsp_multiplier_modes_test;
  import dsp_mult_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int error_cnt = 0;
  int checks_done = 0;
  logic [17:0] sh_a [4];
  logic [17:0] sh_b [4];
  logic [4:0] opw = 5'h12;
  logic [4:0] wl [4] = '{5'h09, 5'h0a, 5'h0d, 5'h12};
  logic [31:0] rd;
  logic er;
  logic s;
  logic [71:0] res;
  logic [71:0] exp_v;

  dsp_link_if link ();
  dsp_half_block u_dsp_half_block (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .link(link));
  dsp_fabric_ctrl u_dsp_fabric_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(link));
  dsp_link_asserts u_dsp_link_asserts (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .kind(link.kind), .op_width(link.op_width), .subtract(link.subtract),
    .stages(link.stages), .a(link.a), .b(link.b), .sign_a(link.sign_a),
    .sign_b(link.sign_b), .zero_loopback(link.zero_loopback),
    .round(link.round), .saturate(link.saturate), .ena(link.ena),
    .aclr(link.aclr), .result(link.result));

  always #5 mclk_i = ~mclk_i;

  function automatic logic [35:0] pm(input logic [17:0] x,
      input logic [17:0] y, input logic sg);
    logic signed [37:0] p;
    p = $signed({sg & x[17], x}) * $signed({sg & y[17], y});
    return p[35:0];
  endfunction

  function automatic logic [35:0] s2(input int i, input int j,
      input logic sb);
    logic [35:0] p0;
    logic [35:0] p1;
    p0 = pm(sh_a[i], sh_b[i], 1'b1);
    p1 = pm(sh_a[j], sh_b[j], 1'b1);
    return sb ? p0 - p1 : p0 + p1;
  endfunction

  // Round adds half of bit 18, then drops bits 17..0
  function automatic logic [35:0] rn(input logic [35:0] x);
    return (x + 36'h0_0002_0000) & 36'hf_fffc_0000;
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Handshake signals are flops, so values read at the edge are sampled
  task automatic xfer(input logic [7:0] ad, input logic w,
      input logic [31:0] wd);
    @(posedge mclk_i);
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    psel <= 1'b1;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_res();
    xfer(OFS_RES, 1'b0, 32'h0000_0000);
    res[31:0] = rd;
    xfer(OFS_RES + 8'h04, 1'b0, 32'h0000_0000);
    res[63:32] = rd;
    xfer(OFS_RES + 8'h08, 1'b0, 32'h0000_0000);
    res[71:64] = rd[7:0];
  endtask

  // Fabric pads raw operands with zeros on the right, so the lane holds them MSB first
  task automatic op(input int k, input logic [17:0] av,
      input logic [17:0] bv);
    sh_a[k] = av << (5'h12 - opw);
    sh_b[k] = bv << (5'h12 - opw);
    xfer(OFS_OPA + 8'(4 * k), 1'b1, {14'h0, av});
    xfer(OFS_OPB + 8'(4 * k), 1'b1, {14'h0, bv});
  endtask

  task automatic cfg(input kind_type kd, input logic [4:0] w,
      input logic sb, input logic [4:0] stg);
    opw = w;
    xfer(OFS_CFG, 1'b1, {17'h0, stg, sb, w, 1'b0, kd});
  endtask

  task automatic dyn(input logic sg, input logic zl, input logic rs,
      input logic [3:0] en);
    xfer(OFS_DYN, 1'b1, {20'h0, en, 3'h0, rs, rs, zl, sg, sg});
  endtask

  initial begin
    #50000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    xfer(OFS_CFG, 1'b0, 32'h0000_0000);
    chk(72'(rd), 72'h120);
    xfer(OFS_DYN, 1'b0, 32'h0000_0000);
    chk(72'(rd), 72'hf00);
    foreach (wl[i]) begin
      s = wl[i] == 5'h12;
      cfg(KIND_IND, wl[i], 1'b0, 5'h00);
      dyn(s, 1'b0, wl[i] < 5'h0d, 4'hf);
      for (int k = 0; k < 4; k++) begin
        op(k, (18'h1 << (wl[i] - 5'h01)) + 18'h3 + 18'(k * 7),
           (18'h1 << wl[i]) - 18'h1 - 18'(k));
      end
      exp_v = {pm(sh_a[1], sh_b[1], s), pm(sh_a[0], sh_b[0], s)};
      for (int k = 0; k < 4; k++) begin
        if (wl[i] < 5'h0a) begin
          exp_v[18 * k +: 18] = sh_a[k][17:9] * sh_b[k][17:9];
        end else if (wl[i] < 5'h0d && k < 3) begin
          exp_v[24 * k +: 24] = sh_a[k][17:6] * sh_b[k][17:6];
        end
      end
      rd_res();
      chk(res, exp_v);
    end
    dyn(1'b1, 1'b0, 1'b1, 4'hf);
    rd_res();
    exp_v = {rn(pm(sh_a[1], sh_b[1], 1'b1)),
             rn(pm(sh_a[0], sh_b[0], 1'b1))};
    chk(res, exp_v);
    op(0, 18'h3_a5c3, 18'h2_f00d);
    op(1, 18'h1_2345, 18'h3_ffff);
    for (int i = 0; i < 2; i++) begin
      cfg(i ? KIND_DOUBLE : KIND_M36, 5'h12, 1'b0, 5'h00);
      dyn(i[0], 1'b0, 1'b0, 4'hf);
      rd_res();
      chk(res, {sh_a[1], sh_a[0]} * {sh_b[1], sh_b[0]});
    end
    cfg(KIND_ADD2, 5'h12, 1'b0, 5'h00);
    dyn(1'b0, 1'b0, 1'b0, 4'hf);
    xfer(OFS_STAT, 1'b0, 32'h0000_0000);
    chk(72'(rd[0]), 72'h1);
    dyn(1'b1, 1'b0, 1'b0, 4'hf);
    op(0, 18'h0_0003, 18'h3_fffb);
    op(1, 18'h0_0007, 18'h0_0002);
    op(2, 18'h0_0064, 18'h0_00c8);
    op(3, 18'h3_ffff, 18'h3_ffff);
    for (int sb = 0; sb < 2; sb++) begin
      cfg(KIND_ADD2, 5'h12, sb[0], 5'h00);
      rd_res();
      chk(res, {s2(2, 3, sb[0]), s2(0, 1, sb[0])});
    end
    xfer(OFS_STAT, 1'b0, 32'h0000_0000);
    chk(72'(rd[0]), 72'h0);
    cfg(KIND_CPLX, 5'h12, 1'b0, 5'h00);
    dyn(1'b0, 1'b0, 1'b0, 4'hf);
    op(0, 18'h3_ffff, 18'h0_0003);
    op(1, 18'h0_0002, 18'h3_fffe);
    rd_res();
    exp_v = {pm(sh_a[0], sh_b[1], 1'b1) + pm(sh_a[1], sh_b[0], 1'b1),
             pm(sh_a[0], sh_b[0], 1'b1) - pm(sh_a[1], sh_b[1], 1'b1)};
    chk(res, exp_v);
    // Lane 0 a operand is replaced by the loop, so its raw value is junk
    cfg(KIND_LOOP, 5'h12, 1'b0, 5'h00);
    op(0, 18'h3_0000, 18'h0_0001);
    op(1, 18'h0_0010, 18'h0_4000);
    for (int zl = 1; zl >= 0; zl--) begin
      dyn(1'b1, zl[0], 1'b0, 4'hf);
      rd_res();
      chk(72'(res[35:0]), zl ? 72'h4_0000 : 72'h4_0001);
    end
    cfg(KIND_IND, 5'h12, 1'b0, 5'h1f);
    dyn(1'b0, 1'b0, 1'b0, 4'hf);
    op(0, 18'h0_0005, 18'h0_0006);
    repeat (6) @(posedge mclk_i);
    rd_res();
    chk(72'(res[35:0]), 72'h1e);
    dyn(1'b0, 1'b0, 1'b0, 4'h0);
    op(0, 18'h0_0007, 18'h0_0006);
    repeat (6) @(posedge mclk_i);
    rd_res();
    chk(72'(res[35:0]), 72'h1e);
    xfer(OFS_CLR, 1'b1, 32'h0000_0008);
    rd_res();
    chk(res, 72'h0);
    dyn(1'b0, 1'b0, 1'b0, 4'hf);
    repeat (6) @(posedge mclk_i);
    rd_res();
    chk(72'(res[35:0]), 72'h2a);
    xfer(8'h40, 1'b0, 32'h0000_0000);
    chk(72'(er), 72'h1);
    xfer(8'h3c, 1'b0, 32'h0000_0000);
    chk(72'(er), 72'h1);
    print_verdict();
  end
endmodule
